// *** core/zc_defines.svh ***
// Register map, field positions, reset value and timing figures of the zero-cross detector
`ifndef ZC_DEFINES_SVH
`define ZC_DEFINES_SVH

`define ZC_SETUP_OFFSET 16'h04a0
`define ZC_SETUP_RESET 32'h0002_3210
`define ZC_SETUP_WMASK 32'h0003_7f1f
`define ZC_FILTER_LSB 8
`define ZC_FILTER_W 7
`define ZC_FIRST_PEAK_BIT 16
`define ZC_SECOND_PEAK_BIT 17
`define ZC_CLK_HZ 200000000
// Mains band: 50 Hz - 10 % up to 60 Hz + 10 %
`define ZC_MAINS_MIN_HZ 45
`define ZC_MAINS_MAX_HZ 66
// Shortest event spacing is half the fastest mains period, longest is one slowest period
`define ZC_MIN_SPACING_CYC (`ZC_CLK_HZ / (2 * `ZC_MAINS_MAX_HZ))
`define ZC_MAX_SPACING_CYC (`ZC_CLK_HZ / `ZC_MAINS_MIN_HZ)

`endif

// *** core/zc_pkg.sv ***
// Types shared by the zero-cross detector
`default_nettype none
package zc_pkg;

  typedef struct packed {
    logic [13:0] reserved_hi;
    logic second_peak_capture_enable;
    logic first_peak_capture_enable;
    logic reserved_15;
    logic [6:0] filter_len;
    logic [2:0] reserved_lo;
    logic glitch_filter_bypass;
    logic period_halving;
    logic input_invert;
    logic falling_edge_choice;
    logic single_direction_select;
  } zero_cross_setup_t;

  typedef enum logic [1:0] {
    ST_ACQUIRE = 2'b01,
    ST_TRACK = 2'b10
  } track_state_t;

  typedef struct packed {
    logic first_peak;
    logic second_peak;
  } peak_events_t;

endpackage
`default_nettype wire

// *** core/mains_zero_cross_detector.sv ***
// Mains zero-crossing detector: input filter, conditioning, prediction loop and setup register
`include "zc_defines.svh"
`default_nettype none

// Operation
// - Track and predict 50/60 Hz mains crossings within ten percent deviation.
// - Midpoint of each conditioned high pulse is a crossing; forecast the next one.
// - Bit 0 clear detects both directions; set detects one, chosen by bit 1.
// - Bit 1 matters only in single-direction mode: 0 rising, 1 falling.
// - Bit 2 set inverts the input before the prediction loop.
// - Bit 3 set halves input period, crossing marked at each input edge.
// - Bit 4 clear enables glitch filter; set bypasses it.
// - Filter accepts a new level only after bits 14:8 cycles of stability.
// - Bit 16 and a first-type peak copy latest crossing time to peak time.
// - Bit 17 and a second-type peak copy latest crossing time to peak time.
module mains_zero_cross_detector #(
  parameter int TW = 32,
  parameter int MIN_SPACING = `ZC_MIN_SPACING_CYC,
  parameter int MAX_SPACING = `ZC_MAX_SPACING_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic mains_sense_input_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  input wire zc_pkg::peak_events_t peak_i,
  output logic zero_cross_flag_o,
  output logic [TW-1:0] latest_crossing_timestamp_o,
  output logic [TW-1:0] peak_crossing_timestamp_o
);

  // ----------------------------------------------------------------
  // Setup register
  // ----------------------------------------------------------------
  zc_pkg::zero_cross_setup_t setup_q;
  logic sel_setup;
  assign sel_setup = (reg_addr_i == `ZC_SETUP_OFFSET);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      setup_q <= `ZC_SETUP_RESET;
    end else if (reg_wr_i && sel_setup) begin
      setup_q <= reg_wdata_i & `ZC_SETUP_WMASK;
    end
  end

  // Unmapped addresses and idle cycles read zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i && sel_setup) begin
      reg_rdata_o <= setup_q & `ZC_SETUP_WMASK;
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchroniser and glitch filter
  // ----------------------------------------------------------------
  logic sync1_q, sync2_q, filt_q;
  logic [6:0] stable_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= mains_sense_input_i;
      sync2_q <= sync1_q;
    end
  end

  // Counts cycles the synchronised level has differed from the accepted one
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stable_q <= 7'h00;
      filt_q <= 1'b0;
    end else if (setup_q.glitch_filter_bypass) begin
      stable_q <= 7'h00;
      filt_q <= sync2_q;
    end else if (sync2_q == filt_q) begin
      stable_q <= 7'h00;
    end else if (stable_q + 7'h01 >= setup_q.filter_len) begin
      stable_q <= 7'h00;
      filt_q <= sync2_q;
    end else begin
      stable_q <= stable_q + 7'h01;
    end
  end

  // ----------------------------------------------------------------
  // Input conditioning stage
  // ----------------------------------------------------------------
  logic cond, cond_q, rise, fall;
  assign cond = filt_q ^ setup_q.input_invert;
  assign rise = cond && !cond_q;
  assign fall = !cond && cond_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cond_q <= 1'b0;
    end else begin
      cond_q <= cond;
    end
  end

  // Free-running time base shared by stamps and prediction
  logic [TW-1:0] tmr_q, rise_t_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tmr_q <= '0;
    end else begin
      tmr_q <= tmr_q + TW'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rise_t_q <= '0;
    end else if (rise) begin
      rise_t_q <= tmr_q;
    end
  end

  // Crossing events: pulse midpoints, or each edge when halving; without halving the
  // direction simply alternates, so single-direction picks every other pulse.
  logic ev_valid, ev_dir, ev_acc, par_q;
  logic [TW-1:0] ev_time;

  always_comb begin
    if (setup_q.period_halving) begin
      ev_valid = rise || fall;
      ev_time = tmr_q;
      ev_dir = fall;
    end else begin
      ev_valid = fall;
      ev_time = rise_t_q + ((tmr_q - rise_t_q) >> 1);
      ev_dir = par_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      par_q <= 1'b0;
    end else if (fall && !setup_q.period_halving) begin
      par_q <= !par_q;
    end
  end

  assign ev_acc = ev_valid && (!setup_q.single_direction_select || (ev_dir == setup_q.falling_edge_choice));

  // ----------------------------------------------------------------
  // Prediction loop
  // ----------------------------------------------------------------
  zc_pkg::track_state_t state_q;
  logic [TW-1:0] prev_q, period_q, pred_q, spacing;
  logic in_band, have_prev_q, fire, lost;
  assign spacing = ev_time - prev_q;
  assign in_band = (spacing >= TW'(MIN_SPACING)) && (spacing <= TW'(MAX_SPACING));
  assign fire = (state_q == zc_pkg::ST_TRACK) && (tmr_q == pred_q);
  assign lost = have_prev_q && ((tmr_q - prev_q) > TW'(2 * MAX_SPACING));

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= zc_pkg::ST_ACQUIRE;
      prev_q <= '0;
      period_q <= '0;
      pred_q <= '0;
      have_prev_q <= 1'b0;
    end else if (ev_acc) begin
      prev_q <= ev_time;
      have_prev_q <= 1'b1;
      if (have_prev_q && in_band) begin
        case (state_q)
          zc_pkg::ST_ACQUIRE: begin
            period_q <= spacing;
            pred_q <= ev_time + spacing;
            state_q <= zc_pkg::ST_TRACK;
          end
          zc_pkg::ST_TRACK: begin
            // Halfway averaging trades tracking speed for jitter immunity
            period_q <= TW'(({1'b0, period_q} + {1'b0, spacing}) >> 1);
            pred_q <= ev_time + TW'(({1'b0, period_q} + {1'b0, spacing}) >> 1);
          end
          default: state_q <= zc_pkg::ST_ACQUIRE;
        endcase
      end else if (have_prev_q) begin
        state_q <= zc_pkg::ST_ACQUIRE;
      end
    end else if (lost) begin
      state_q <= zc_pkg::ST_ACQUIRE;
      have_prev_q <= 1'b0;
    end else if (fire) begin
      pred_q <= pred_q + period_q; // keeps forecasting between measured pulses
    end
  end

  // ----------------------------------------------------------------
  // Flag and timestamps
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      zero_cross_flag_o <= 1'b0;
      latest_crossing_timestamp_o <= '0;
    end else begin
      zero_cross_flag_o <= fire;
      if (fire) begin
        latest_crossing_timestamp_o <= tmr_q;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      peak_crossing_timestamp_o <= '0;
    end else if ((peak_i.first_peak && setup_q.first_peak_capture_enable) ||
                 (peak_i.second_peak && setup_q.second_peak_capture_enable)) begin
      peak_crossing_timestamp_o <= latest_crossing_timestamp_o;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  flag_cause_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    zero_cross_flag_o |-> $past(state_q) == zc_pkg::ST_TRACK && latest_crossing_timestamp_o == $past(tmr_q))
    else $error("crossing flag without a matching forecast");

  // Checked against the raw edges and parity, not against the direction mux itself
  direction_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ev_acc && setup_q.single_direction_select
    |-> (setup_q.period_halving ? (setup_q.falling_edge_choice ? fall : rise)
                                : (par_q == setup_q.falling_edge_choice)))
    else $error("crossing of the wrong direction accepted");

  both_dir_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ev_valid && !setup_q.single_direction_select |-> ev_acc)
    else $error("crossing dropped in both-direction mode");

  bypass_path_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    setup_q.glitch_filter_bypass && $past(setup_q.glitch_filter_bypass) |-> filt_q == $past(sync2_q))
    else $error("bypassed filter does not follow input");

  filter_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !setup_q.glitch_filter_bypass && $past(!setup_q.glitch_filter_bypass) && $changed(filt_q)
    |-> $past(stable_q) + 7'h01 >= $past(setup_q.filter_len))
    else $error("filter accepted a level too early");

  invert_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ##1 $stable(setup_q.input_invert) |-> cond_q == ($past(filt_q) ^ setup_q.input_invert))
    else $error("conditioned level has wrong polarity");

  peak_copy_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    peak_i.first_peak && setup_q.first_peak_capture_enable
    |=> peak_crossing_timestamp_o == $past(latest_crossing_timestamp_o))
    else $error("peak time not captured");

  peak_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(peak_i.first_peak && setup_q.first_peak_capture_enable) &&
    !(peak_i.second_peak && setup_q.second_peak_capture_enable) |=> $stable(peak_crossing_timestamp_o))
    else $error("peak time changed without an enabled peak");

  reserved_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (reg_rdata_o & ~`ZC_SETUP_WMASK) == 32'h0000_0000)
    else $error("reserved bits read non-zero");

endmodule
`default_nettype wire

// *** sim/zc_mains_source.sv ***
// Behavioural mains sensing circuit driving the zero-cross pin
`default_nettype none
module zc_mains_source (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic glitch_i,
  input wire logic [15:0] period_i,
  input wire logic [15:0] high_len_i,
  output logic [15:0] phase_o,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_i) begin
    if (!run_i || phase_o == period_i - 16'd1) begin
      phase_o <= 16'h0000;
    end else begin
      phase_o <= phase_o + 16'd1;
    end
  end
  // One pulse per period, duty kept under forty percent by the bench
  // Pin has a pull-down, so a stopped source reads low; the glitch is a 3-cycle spike
  assign line_o = run_i && (phase_o < high_len_i || (glitch_i && phase_o >= 16'd120 && phase_o < 16'd123));
endmodule
`default_nettype wire

// *** sim/mains_zero_cross_detector_bench.sv ***
// Self-checking bench for the mains zero-crossing detector
`default_nettype none
module mains_zero_cross_detector_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] ADDR = 16'h04a0;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [15:0] reg_addr_i = 16'h0000;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic [31:0] reg_rdata_o;
  zc_pkg::peak_events_t peak_i = 2'b00;
  logic zero_cross_flag_o;
  logic [31:0] latest_ts;
  logic [31:0] peak_ts;
  logic line;
  logic run = 1'b0;
  logic glitch = 1'b0;
  logic [15:0] period = 16'd200;
  logic [15:0] high_len = 16'd40;
  logic [15:0] phase;
  logic [31:0] cyc = 32'h0000_0000;
  logic [31:0] rd;
  int miscompares = 0;
  int tests_run = 0;

  // Short spacing band keeps each lock within a few hundred cycles
  mains_zero_cross_detector #(.TW(32), .MIN_SPACING(20), .MAX_SPACING(400)) DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .mains_sense_input_i(line), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .peak_i(peak_i), .zero_cross_flag_o(zero_cross_flag_o), .latest_crossing_timestamp_o(latest_ts),
    .peak_crossing_timestamp_o(peak_ts));
  zc_mains_source src (.clk_i(clk_i), .run_i(run), .glitch_i(glitch), .period_i(period),
    .high_len_i(high_len), .phase_o(phase), .line_o(line));

  initial forever #2.5 clk_i = ~clk_i;
  always_ff @(posedge clk_i) cyc <= cyc + 32'h0000_0001;

  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_write(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic reg_read(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask
  task automatic wait_flag(output logic [31:0] t, output logic [15:0] ph, output logic [31:0] ts);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (zero_cross_flag_o !== 1'b1 && n < 2000);
    check("flag", {31'h0, zero_cross_flag_o}, 32'h0000_0001);
    t = cyc;
    ph = phase;
    ts = latest_ts;
  endtask
  // Input is stopped long enough to drop the loop to acquire, so each mode locks afresh
  task automatic run_mode(input logic [31:0] cfg, input logic [15:0] p, input logic [15:0] h,
                          input logic g, input logic [31:0] sp, input logic [15:0] ph_exp, input logic chk);
    logic [31:0] t0, t1, l0, l1;
    logic [15:0] p0, p1;
    @(posedge clk_i);
    run <= 1'b0;
    reg_write(ADDR, cfg);
    repeat (900) @(posedge clk_i);
    period <= p;
    high_len <= h;
    glitch <= g;
    run <= 1'b1;
    repeat (3000) @(posedge clk_i);
    wait_flag(t0, p0, l0);
    wait_flag(t1, p1, l1);
    check("flag spacing", t1 - t0, sp);
    check("timestamp step", l1 - l0, sp);
    if (chk) check("flag phase", {31'h0, ((p0 + p - ph_exp) % p) < 16'd24}, 32'h0000_0001);
  endtask
  task automatic peak_pulse(input zc_pkg::peak_events_t ev, input logic upd);
    logic [31:0] t, old, l;
    logic [15:0] ph;
    wait_flag(t, ph, l);
    repeat (2) @(posedge clk_i);
    old = peak_ts;
    peak_i <= ev;
    @(posedge clk_i);
    peak_i <= 2'b00;
    @(posedge clk_i);
    #1;
    check("peak timestamp", peak_ts, upd ? latest_ts : old);
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    reg_read(ADDR, rd);
    check("setup reset", rd, 32'h0002_3210);
    reg_write(ADDR, 32'hffff_ffff);
    reg_read(ADDR, rd);
    check("setup reserved", rd, 32'h0003_7f1f);
    reg_write(16'h04a4, 32'h0000_0000);
    reg_read(16'h04a4, rd);
    check("unmapped read", rd, 32'h0000_0000);
    reg_read(ADDR, rd);
    check("unmapped write", rd, 32'h0003_7f1f);
    run_mode(32'h0000_0010, 16'd200, 16'd40, 1'b0, 32'd200, 16'd20, 1'b1);
    run_mode(32'h0000_0014, 16'd200, 16'd40, 1'b0, 32'd200, 16'd120, 1'b1);
    // Glitch would split the pulse if the filter let it through
    run_mode(32'h0000_0a04, 16'd200, 16'd40, 1'b1, 32'd200, 16'd120, 1'b1);
    run_mode(32'h0000_0011, 16'd150, 16'd30, 1'b0, 32'd300, 16'd0, 1'b0);
    run_mode(32'h0000_0019, 16'd300, 16'd90, 1'b0, 32'd300, 16'd0, 1'b1);
    run_mode(32'h0000_001b, 16'd300, 16'd90, 1'b0, 32'd300, 16'd90, 1'b1);
    run_mode(32'h0000_0a0d, 16'd300, 16'd90, 1'b0, 32'd300, 16'd90, 1'b1);
    run_mode(32'h0002_0010, 16'd200, 16'd40, 1'b0, 32'd200, 16'd20, 1'b1);
    peak_pulse(2'b01, 1'b1);
    peak_pulse(2'b10, 1'b0);
    reg_write(ADDR, 32'h0001_0010);
    peak_pulse(2'b10, 1'b1);
    peak_pulse(2'b01, 1'b0);
    tally_and_finish();
  end
  // Whole run is about 40k cycles; twice that means a hang
  initial begin
    #400000;
    miscompares++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
